/* hw/bsrc_pkg.sv */
package bsrc_pkg;

  // ==========================================================
  // Bus cycle states
  typedef enum logic [2:0] {
    BSRC_IDLE,
    BSRC_ADDR,
    BSRC_T2,
    BSRC_T3,
    BSRC_WAIT,
    BSRC_T4
  } bsrc_state_e;

  // ==========================================================
  // Queue status codes, bit one then bit zero
  localparam logic [1:0] QS_NONE = 2'h0;
  localparam logic [1:0] QS_FIRST = 2'h1;
  localparam logic [1:0] QS_NEXT = 2'h3;
  localparam logic [1:0] QS_EMPTY = 2'h2;

  // ==========================================================
  // Lane encodings: upper enable, lowest address bit
  localparam logic [1:0] LANE_WORD = 2'h0;
  localparam logic [1:0] LANE_UPPER = 2'h1;
  localparam logic [1:0] LANE_LOWER = 2'h2;
  localparam logic [1:0] LANE_REFRESH = 2'h3;

  // ==========================================================
  // Strap timing: cycles after reset release before sampling
  localparam logic [1:0] STRAP_DELAY = 2'h3;
  localparam int SYNC_STAGES = 2;

endpackage

/* hw/bsrc_sync.sv */
`timescale 1ns/1ps
// ==========================================================
// Two flip-flop level synchroniser
module bsrc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_r <= '0;
      q_out <= '0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end

endmodule

/* hw/bsrc_ctrl.sv */
`timescale 1ns/1ps
// ==========================================================
// Bus strobe and ready control: one clk_in cycle per T-state
module bsrc_ctrl #(
  parameter int AW = 16,
  parameter bit NARROW_BUS = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  // Core side
  input wire logic req_in,
  input wire logic req_write_in,
  input wire logic req_word_in,
  input wire logic req_refresh_in,
  input wire logic [AW-1:0] req_addr_in,
  input wire logic [AW-1:0] req_wdata_in,
  input wire logic enhanced_mode_in,
  input wire logic [1:0] queue_op_in,
  output logic busy_out,
  output logic done_out,
  output logic [AW-1:0] rdata_out,
  output logic queue_mode_out,
  // Bus pins
  input wire logic [AW-1:0] ad_in,
  output logic [AW-1:0] ad_out,
  output logic ad_oe_out,
  output logic upper_byte_enable_n_out,
  output logic upper_byte_enable_oe_out,
  output logic ale_queue_status_bit_zero_out,
  output logic wr_queue_status_bit_one_out,
  output logic wr_queue_status_bit_one_oe_out,
  input wire logic rd_queue_mode_strap_in,
  output logic rd_out,
  output logic rd_oe_out,
  input wire logic async_ready_in,
  input wire logic sync_ready_in
);

  // ==========================================================
  // Decoding
  function automatic logic [1:0] lane_code(input logic word, input logic refr,
                                           input logic lsb, input logic enh);
    if (refr && enh) begin
      lane_code = bsrc_pkg::LANE_REFRESH;
    end else if (word) begin
      lane_code = bsrc_pkg::LANE_WORD;
    end else if (lsb) begin
      lane_code = bsrc_pkg::LANE_UPPER;
    end else begin
      lane_code = bsrc_pkg::LANE_LOWER;
    end
  endfunction

  bsrc_pkg::bsrc_state_e state_r;
  bsrc_pkg::bsrc_state_e state_nxt;
  logic strap_sync;
  logic async_ready_sync;
  logic [1:0] lane_nxt;
  logic ready_any;
  logic [1:0] strap_cnt_r;
  logic mode_valid_r;
  logic qmode_r;
  logic write_r;
  logic refresh_r;
  logic [1:0] lane_r;
  logic [AW-1:0] wdata_r;
  logic upper_n_nxt;

  // ==========================================================
  // Pin synchronisers
  bsrc_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in({rd_queue_mode_strap_in, async_ready_in}),
    .q_out({strap_sync, async_ready_sync})
  );

  // Either source completes the cycle
  assign ready_any = async_ready_sync | sync_ready_in;
  assign lane_nxt = lane_code(req_word_in, req_refresh_in, req_addr_in[0], enhanced_mode_in);

  // ==========================================================
  // Strap capture after reset release
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      strap_cnt_r <= '0;
      mode_valid_r <= 1'b0;
      qmode_r <= 1'b0;
    end else if (!mode_valid_r) begin
      if (strap_cnt_r == bsrc_pkg::STRAP_DELAY) begin
        mode_valid_r <= 1'b1;
        qmode_r <= ~strap_sync;
      end else begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      queue_mode_out <= 1'b0;
    end else begin
      queue_mode_out <= qmode_r;
    end
  end

  // ==========================================================
  // T-state sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      bsrc_pkg::BSRC_IDLE: begin
        if (req_in && mode_valid_r) begin
          state_nxt = bsrc_pkg::BSRC_ADDR;
        end
      end
      bsrc_pkg::BSRC_ADDR: state_nxt = bsrc_pkg::BSRC_T2;
      bsrc_pkg::BSRC_T2: state_nxt = bsrc_pkg::BSRC_T3;
      bsrc_pkg::BSRC_T3, bsrc_pkg::BSRC_WAIT: begin
        state_nxt = ready_any ? bsrc_pkg::BSRC_T4 : bsrc_pkg::BSRC_WAIT;
      end
      bsrc_pkg::BSRC_T4: state_nxt = bsrc_pkg::BSRC_IDLE;
      default: state_nxt = bsrc_pkg::BSRC_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= bsrc_pkg::BSRC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Request capture
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      write_r <= 1'b0;
      refresh_r <= 1'b0;
      lane_r <= bsrc_pkg::LANE_LOWER;
      wdata_r <= '0;
    end else if (state_r == bsrc_pkg::BSRC_IDLE && state_nxt == bsrc_pkg::BSRC_ADDR) begin
      write_r <= req_write_in & ~req_refresh_in;
      refresh_r <= req_refresh_in;
      lane_r <= lane_nxt;
      wdata_r <= req_wdata_in;
    end
  end

  // ==========================================================
  // Multiplexed address/data bus
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ad_out <= '0;
      ad_oe_out <= 1'b0;
    end else if (state_nxt == bsrc_pkg::BSRC_ADDR) begin
      ad_out <= {req_addr_in[AW-1:1], lane_nxt[0]};
      ad_oe_out <= 1'b1;
    end else if (state_nxt == bsrc_pkg::BSRC_T2) begin
      ad_out <= wdata_r;
      ad_oe_out <= write_r;
    end else if (state_nxt == bsrc_pkg::BSRC_IDLE) begin
      ad_oe_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= '0;
    end else if (state_nxt == bsrc_pkg::BSRC_T4 && !write_r) begin
      rdata_out <= ad_in;
    end
  end

  // ==========================================================
  // Upper enable / refresh strobe pin
  always_comb begin
    if (NARROW_BUS) begin
      upper_n_nxt = ~refresh_r;
    end else begin
      upper_n_nxt = lane_r[1];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      upper_byte_enable_n_out <= 1'b1;
      upper_byte_enable_oe_out <= 1'b0;
    end else if (state_nxt == bsrc_pkg::BSRC_ADDR) begin
      upper_byte_enable_n_out <= NARROW_BUS ? ~req_refresh_in : lane_nxt[1];
      upper_byte_enable_oe_out <= 1'b1;
    end else if (state_nxt == bsrc_pkg::BSRC_IDLE) begin
      upper_byte_enable_n_out <= 1'b1;
      upper_byte_enable_oe_out <= 1'b0;
    end else begin
      upper_byte_enable_n_out <= upper_n_nxt;
    end
  end

  // ==========================================================
  // Latch, write and read strobes or queue status
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ale_queue_status_bit_zero_out <= 1'b0;
    end else if (qmode_r) begin
      ale_queue_status_bit_zero_out <= queue_op_in[0];
    end else begin
      ale_queue_status_bit_zero_out <= (state_nxt == bsrc_pkg::BSRC_ADDR);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_queue_status_bit_one_out <= 1'b1;
      wr_queue_status_bit_one_oe_out <= 1'b0;
    end else if (qmode_r) begin
      wr_queue_status_bit_one_out <= queue_op_in[1];
      wr_queue_status_bit_one_oe_out <= 1'b1;
    end else begin
      wr_queue_status_bit_one_oe_out <= mode_valid_r;
      wr_queue_status_bit_one_out <= ~(write_r && (state_nxt == bsrc_pkg::BSRC_T2 ||
        state_nxt == bsrc_pkg::BSRC_T3 ||
        state_nxt == bsrc_pkg::BSRC_WAIT));
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_out <= 1'b1;
      rd_oe_out <= 1'b0;
    end else if (qmode_r || !mode_valid_r) begin
      rd_out <= 1'b1;
      rd_oe_out <= 1'b0;
    end else begin
      rd_oe_out <= 1'b1;
      rd_out <= ~(!write_r && (state_nxt == bsrc_pkg::BSRC_T2 ||
                               state_nxt == bsrc_pkg::BSRC_T3 ||
                               state_nxt == bsrc_pkg::BSRC_WAIT));
    end
  end

  // ==========================================================
  // Core status
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_out <= 1'b1;
      done_out <= 1'b0;
    end else begin
      busy_out <= ~mode_valid_r || (state_nxt != bsrc_pkg::BSRC_IDLE);
      done_out <= (state_r == bsrc_pkg::BSRC_T4);
    end
  end

endmodule

/* dv/bsrc_mem.sv */
`timescale 1ns/1ps
// ==========================================================
// Far-side memory, ready source and strap on the read pin
module bsrc_mem (
  input wire logic clk_in,
  input wire logic strap_low_in,
  input wire logic [1:0] waits_in,
  input wire logic use_async_in,
  input wire logic [15:0] dev_ad_in,
  input wire logic rd_in,
  input wire logic rd_oe_in,
  input wire logic wr_in,
  input wire logic qmode_in,
  output logic [15:0] bus_ad_out,
  output logic rd_pin_out,
  output logic async_ready_out,
  output logic sync_ready_out
);
  logic [15:0] mem_r = 16'h0;
  logic [1:0] cnt_r = 2'h0;
  logic rdy_r = 1'b0;
  logic act;
  assign act = !qmode_in && ((rd_oe_in && !rd_in) || !wr_in);
  // Released bus shows the inverse of the stored word
  assign bus_ad_out = (rd_oe_in && !rd_in) ? mem_r : ~mem_r;
  assign rd_pin_out = rd_oe_in ? rd_in : !strap_low_in;
  assign sync_ready_out = rdy_r && !use_async_in;
  assign async_ready_out = rdy_r && use_async_in;
  always_ff @(posedge clk_in) begin
    if (!wr_in && !qmode_in) begin
      mem_r <= dev_ad_in;
    end
  end
  always_ff @(posedge clk_in) begin
    cnt_r <= !act ? 2'h0 : (cnt_r == 2'h3 ? cnt_r : cnt_r + 2'h1);
    rdy_r <= act && (cnt_r >= waits_in);
  end
endmodule

/* dv/bsrc_ctrl_sva.sv */
`timescale 1ns/1ps
// ==========================================================
// Strobe and ready checks on the pins
module bsrc_chk (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ad_oe_out,
  input wire logic upper_byte_enable_n_out,
  input wire logic ale_queue_status_bit_zero_out,
  input wire logic wr_queue_status_bit_one_out,
  input wire logic wr_queue_status_bit_one_oe_out,
  input wire logic rd_out,
  input wire logic rd_oe_out,
  input wire logic queue_mode_out,
  input wire logic [1:0] queue_op_in,
  input wire logic async_ready_in,
  input wire logic sync_ready_in
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_addr;
    ale_queue_status_bit_zero_out && !queue_mode_out;
  endsequence
  sequence s_t2;
    $fell(rd_out) && rd_oe_out && !queue_mode_out;
  endsequence
  AST_ALE_PULSE: assert property (s_addr |=> !ale_queue_status_bit_zero_out)
    else $error("ale long");
  AST_ALE_ADDR: assert property (s_addr |-> ad_oe_out)
    else $error("ale no addr");
  AST_UBE_HOLD: assert property (s_addr |=> $stable(upper_byte_enable_n_out) [*2])
    else $error("enable moved");
  AST_RD_FLOAT: assert property (!rd_out && rd_oe_out |-> !ad_oe_out)
    else $error("rd on driven bus");
  AST_WR_DATA: assert property (!wr_queue_status_bit_one_out &&
    wr_queue_status_bit_one_oe_out && !queue_mode_out |-> ad_oe_out) else $error("wr no data");
  AST_QS_MAP: assert property (queue_mode_out && $past(queue_mode_out) |->
    {wr_queue_status_bit_one_out, ale_queue_status_bit_zero_out} == $past(queue_op_in))
    else $error("queue code");
  AST_QMODE_RD: assert property (queue_mode_out |-> !rd_oe_out)
    else $error("rd driven");
  AST_RDY_END: assert property (s_t2 ##1 sync_ready_in |=> rd_out)
    else $error("no end");
  AST_NO_RDY: assert property (s_t2 ##1 (!sync_ready_in && !async_ready_in &&
    !$past(async_ready_in) && !$past(async_ready_in, 2)) |=> !rd_out) else $error("no wait");
endmodule

bind bsrc_ctrl bsrc_chk u_bsrc_chk (.clk_in, .rst_in, .ad_oe_out, .upper_byte_enable_n_out,
  .ale_queue_status_bit_zero_out, .wr_queue_status_bit_one_out,
  .wr_queue_status_bit_one_oe_out, .rd_out, .rd_oe_out, .queue_mode_out,
  .queue_op_in, .async_ready_in, .sync_ready_in);

/* dv/bsrc_ctrl_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module bsrc_ctrl_tb;
  logic clk_in, rst_in, req_in, req_write_in, req_word_in, req_refresh_in, enhanced_mode_in;
  logic [15:0] req_addr_in, req_wdata_in, ad_in, ad_out, rdata_out;
  logic [1:0] queue_op_in, waits;
  logic busy_out, done_out, queue_mode_out, ad_oe_out, upper_byte_enable_n_out, use_async;
  logic upper_byte_enable_oe_out, ale_queue_status_bit_zero_out, wr_queue_status_bit_one_out;
  logic wr_queue_status_bit_one_oe_out, rd_queue_mode_strap_in;
  logic rd_out, rd_oe_out, async_ready_in, sync_ready_in, strap_low;
  int n_errors = 0;
  int total_checks = 0;
  int n0, n;
  bsrc_ctrl u_bsrc_ctrl (.clk_in, .rst_in, .req_in, .req_write_in, .req_word_in,
    .req_refresh_in, .req_addr_in, .req_wdata_in, .enhanced_mode_in, .queue_op_in, .busy_out,
    .done_out, .rdata_out, .queue_mode_out, .ad_in, .ad_out, .ad_oe_out,
    .upper_byte_enable_n_out, .upper_byte_enable_oe_out, .ale_queue_status_bit_zero_out,
    .wr_queue_status_bit_one_out, .wr_queue_status_bit_one_oe_out, .rd_queue_mode_strap_in,
    .rd_out, .rd_oe_out, .async_ready_in, .sync_ready_in);
  bsrc_mem u_bsrc_mem (.clk_in, .strap_low_in(strap_low), .waits_in(waits),
    .use_async_in(use_async), .dev_ad_in(ad_out), .rd_in(rd_out), .rd_oe_in(rd_oe_out),
    .wr_in(wr_queue_status_bit_one_out), .qmode_in(queue_mode_out), .bus_ad_out(ad_in),
    .rd_pin_out(rd_queue_mode_strap_in), .async_ready_out(async_ready_in),
    .sync_ready_out(sync_ready_in));
  task automatic finish_test;
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic reset_dut;
    int k = 0;
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    while (busy_out !== 1'b0 && k < 20) begin
      @(posedge clk_in);
      #1;
      k++;
    end
    `CHK(busy_out, 1'b0)
  endtask
  // One bus cycle; counts cycles from address state to completion
  task automatic cyc(input logic w, wd, rf, input logic [15:0] a, input logic [1:0] lane);
    logic seen = 1'b0;
    n = 0;
    @(posedge clk_in);
    {req_in, req_write_in, req_word_in, req_refresh_in} <= {1'b1, w, wd, rf};
    req_addr_in <= a;
    @(posedge clk_in);
    req_in <= 1'b0;
    #1;
    while (done_out !== 1'b1 && n < 40) begin
      if (ale_queue_status_bit_zero_out === 1'b1) begin
        seen = 1'b1;
        `CHK({upper_byte_enable_n_out, ad_out[0]}, lane)
        `CHK({upper_byte_enable_oe_out, ad_oe_out, ad_out}, {2'h3, a[15:1], lane[0]})
      end
      @(posedge clk_in);
      #1;
      n++;
    end
    `CHK(seen, 1'b1)
    `CHK(done_out, 1'b1)
    `CHK({upper_byte_enable_oe_out, upper_byte_enable_n_out}, 2'h1)
  endtask
  task automatic t_lanes;
    `CHK(queue_mode_out, 1'b0)
    cyc(1'b1, 1'b1, 1'b0, 16'h1230, bsrc_pkg::LANE_WORD);
    cyc(1'b0, 1'b1, 1'b0, 16'h1230, bsrc_pkg::LANE_WORD);
    n0 = n;
    `CHK(n0, 4)
    `CHK(rdata_out, 16'ha5c3)
    cyc(1'b0, 1'b0, 1'b0, 16'h1231, bsrc_pkg::LANE_UPPER);
    cyc(1'b1, 1'b0, 1'b0, 16'h1232, bsrc_pkg::LANE_LOWER);
    cyc(1'b0, 1'b0, 1'b1, 16'h1230, bsrc_pkg::LANE_REFRESH);
    enhanced_mode_in <= 1'b0;
    cyc(1'b0, 1'b0, 1'b1, 16'h1231, bsrc_pkg::LANE_UPPER);
  endtask
  task automatic t_waits;
    waits <= 2'h2;
    cyc(1'b0, 1'b1, 1'b0, 16'h1230, bsrc_pkg::LANE_WORD);
    `CHK(n - n0, 2)
    waits <= 2'h0;
    use_async <= 1'b1;
    cyc(1'b0, 1'b1, 1'b0, 16'h1230, bsrc_pkg::LANE_WORD);
    `CHK(n - n0, 2)
    `CHK(rdata_out, 16'ha5c3)
    use_async <= 1'b0;
  endtask
  task automatic t_queue;
    logic [1:0] codes [4] = '{bsrc_pkg::QS_NONE, bsrc_pkg::QS_FIRST, bsrc_pkg::QS_NEXT,
      bsrc_pkg::QS_EMPTY};
    strap_low <= 1'b1;
    reset_dut();
    `CHK(queue_mode_out, 1'b1)
    `CHK(rd_oe_out, 1'b0)
    `CHK(wr_queue_status_bit_one_oe_out, 1'b1)
    foreach (codes[i]) begin
      @(posedge clk_in);
      queue_op_in <= codes[i];
      @(posedge clk_in);
      #1;
      `CHK({wr_queue_status_bit_one_out, ale_queue_status_bit_zero_out}, codes[i])
    end
  endtask
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    n_errors++;
    finish_test();
  end
  initial begin
    {rst_in, req_in, req_write_in, req_word_in, req_refresh_in} = 5'h10;
    {enhanced_mode_in, use_async, strap_low} = 3'h4;
    {req_addr_in, req_wdata_in, queue_op_in, waits} = {16'h0, 16'ha5c3, 4'h0};
    reset_dut();
    t_lanes();
    t_waits();
    t_queue();
    finish_test();
  end
endmodule
